// ### core/evc_pkg.sv
package evc_pkg;

    // event type, precision and class encodings
    typedef enum logic [1:0]
    {
        EVC_TYPE_NONE  = 2'b00,
        EVC_TYPE_FAULT = 2'b01,
        EVC_TYPE_TRAP  = 2'b10,
        EVC_TYPE_ABORT = 2'b11
    } evc_type_e;

    typedef enum logic [1:0]
    {
        EVC_PREC_NONE = 2'b00,
        EVC_PREC_YES  = 2'b01,
        EVC_PREC_NO   = 2'b10
    } evc_prec_e;

    typedef enum logic [1:0]
    {
        EVC_CLASS_NONE    = 2'b00,
        EVC_CLASS_BENIGN  = 2'b01,
        EVC_CLASS_CONTRIB = 2'b10
    } evc_class_e;

    // fixed vectors
    localparam logic [7:0] VEC_DIVIDE     = 8'h00;
    localparam logic [7:0] VEC_DEBUG      = 8'h01;
    localparam logic [7:0] VEC_NMI        = 8'h02;
    localparam logic [7:0] VEC_BREAKPOINT = 8'h03;
    localparam logic [7:0] VEC_OVERFLOW   = 8'h04;
    localparam logic [7:0] VEC_BOUND      = 8'h05;
    localparam logic [7:0] VEC_OPCODE     = 8'h06;
    localparam logic [7:0] VEC_DEVICE     = 8'h07;
    localparam logic [7:0] VEC_DOUBLE     = 8'h08;
    localparam logic [7:0] VEC_OVERRUN    = 8'h09;
    localparam logic [7:0] VEC_TASKSEG    = 8'h0A;
    localparam logic [7:0] VEC_NOTPRESENT = 8'h0B;
    localparam logic [7:0] VEC_STACK      = 8'h0C;
    localparam logic [7:0] VEC_PROTECT    = 8'h0D;
    localparam logic [7:0] VEC_PAGE       = 8'h0E;
    localparam logic [7:0] VEC_RSVD15     = 8'h0F;
    localparam logic [7:0] VEC_FPU        = 8'h10;
    localparam logic [7:0] VEC_ALIGN      = 8'h11;
    localparam logic [7:0] VEC_MACHINE    = 8'h12;
    localparam logic [7:0] VEC_SIMD       = 8'h13;
    localparam logic [7:0] VEC_HYPER      = 8'h1C;
    localparam logic [7:0] VEC_VMMCOMM    = 8'h1D;
    localparam logic [7:0] VEC_SECURITY   = 8'h1E;
    localparam logic [7:0] VEC_RSVD31     = 8'h1F;
    localparam logic [7:0] VEC_PREDEF_TOP = 8'h20;

    // source index on the request vector, also the priority order (0 highest)
    localparam int SRC_DOUBLE   = 0;
    localparam int SRC_MACHINE  = 1;
    localparam int SRC_DEBUG    = 2;
    localparam int SRC_DIVIDE   = 3;
    localparam int SRC_TASKSEG  = 4;
    localparam int SRC_STACK    = 5;
    localparam int SRC_PROTECT  = 6;
    localparam int SRC_PAGE     = 7;
    localparam int SRC_ALIGN    = 8;
    localparam int SRC_DEVICE   = 9;
    localparam int SRC_HYPER    = 10;
    localparam int SRC_VMMCOMM  = 11;
    localparam int SRC_SECURITY = 12;
    localparam int SRC_COUNT    = 13;

    // control-word bit positions for the disable enables
    localparam int CW0_DEVICE_EN_BIT  = 0;
    localparam int CW4_ALIGN_EN_BIT   = 0;
    localparam int CW4_MACHINE_EN_BIT = 1;

    localparam logic [1:0] PRIV_KERNEL    = 2'h0;
    localparam int         BKPT_COUNT     = 4;

    typedef struct packed
    {
        logic       valid;
        logic [7:0] vector;
        evc_type_e  evType;
        evc_prec_e  precise;
        evc_class_e evClass;
        logic       isNmi;
        logic       isExt;
    } evc_event_s;

    typedef struct packed
    {
        evc_event_s           out;
        logic [SRC_COUNT-1:0] heldMasked;
        logic                 nmiPending;
        logic                 nmiBlocked;
        logic                 deviceEn;
        logic                 alignEn;
        logic                 machineEn;
        logic [BKPT_COUNT-1:0] bkptEn;
    } evc_state_s;

    localparam logic [SRC_COUNT-1:0] RESET_MASKED = '0;

endpackage

// ### core/evc_classifier.sv
// Behaviour
// - disabled conditions ignored; masked ones recognised but held, not delivered
// - align, device and machine-check enables writable only at privilege zero
// - eight-bit vector space, 256 distinct vectors
// - vectors below 32 tied to fixed predefined sources
// - software interrupt may raise any vector, predefined range included
// - accepted event's vector output for service routine lookup
// - divide error gives vector 0, contributory fault
// - debug event gives vector 1, precise, fault or trap
// - nested exception gives vector 8, imprecise abort
// - task segment failure gives vector 10, contributory fault
// - stack fault gives vector 12, precise contributory fault
// - protection violation gives vector 13, contributory fault
// - page fault gives vector 14, benign or contributory fault
// - vectors 28 benign, 29 and 30 precise contributory
// - external maskable interrupt any vector, untyped, benign
// - reserved vectors 9, 15, 20-27, 31 never raised by predefined events
// - each breakpoint condition individually enabled before it triggers
// - external interrupt delivered only with interrupt enable flag, else pending
// - non-maskable interrupt at boundary, vector 2, blocked until return
`timescale 1ns/10ps
`default_nettype none
module evc_classifier
    import evc_pkg::*;
(
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  sys_rst,
    // execution-stage exception sources, one-cycle events
    input  wire logic [SRC_COUNT-1:0]  srcEvent,
    input  wire logic                  debugIsTrap,
    input  wire logic                  pageContrib,
    input  wire logic [BKPT_COUNT-1:0] bkptHit,
    input  wire logic                  deliveryMask,
    // software interrupt instruction
    input  wire logic                  swIntReq,
    input  wire logic [7:0]            swIntVector,
    // external maskable interrupt, held until accepted
    input  wire logic                  external_maskable_irq,
    input  wire logic [7:0]            extVector,
    output logic                       extAck,
    // non-maskable interrupt
    input  wire logic                  nmiReq,
    input  wire logic                  irqReturnDone,
    input  wire logic                  instrBoundary,
    // control words and privilege
    input  wire logic                  interrupt_enable_flag,
    input  wire logic [1:0]            current_privilege_level,
    input  wire logic                  cwWrite,
    input  wire logic [7:0]            control_word_zero,
    input  wire logic [7:0]            control_word_four,
    input  wire logic                  bkptWrite,
    input  wire logic [BKPT_COUNT-1:0] bkptEnableIn,
    // enable, nmi block and held-event status
    output logic                       deviceEnabled,
    output logic                       alignEnabled,
    output logic                       machineEnabled,
    output logic [BKPT_COUNT-1:0]      bkptEnabled,
    output logic                       nmiBlocked,
    output logic [SRC_COUNT-1:0]       heldEvents,
    // accepted event
    output evc_event_s                 accepted
);

    evc_state_s stateQ;
    evc_state_s stateD;

    // fixed attributes of a predefined source
    function automatic evc_event_s classify(input int src, input logic dbgTrap, input logic pgContrib);
        evc_event_s e;
        e = '0;
        e.valid = 1'b1;
        unique case (src)
            SRC_DOUBLE:   begin e.vector = VEC_DOUBLE;   e.evType = EVC_TYPE_ABORT; e.precise = EVC_PREC_NO;   e.evClass = EVC_CLASS_NONE;    end
            SRC_MACHINE:  begin e.vector = VEC_MACHINE;  e.evType = EVC_TYPE_ABORT; e.precise = EVC_PREC_NO;   e.evClass = EVC_CLASS_BENIGN;  end
            SRC_DEBUG:    begin e.vector = VEC_DEBUG;    e.evType = dbgTrap ? EVC_TYPE_TRAP : EVC_TYPE_FAULT;
                                e.precise = EVC_PREC_YES; e.evClass = EVC_CLASS_BENIGN; end
            SRC_DIVIDE:   begin e.vector = VEC_DIVIDE;   e.evType = EVC_TYPE_FAULT; e.precise = EVC_PREC_YES;  e.evClass = EVC_CLASS_CONTRIB; end
            SRC_TASKSEG:  begin e.vector = VEC_TASKSEG;  e.evType = EVC_TYPE_FAULT; e.precise = EVC_PREC_YES;  e.evClass = EVC_CLASS_CONTRIB; end
            SRC_STACK:    begin e.vector = VEC_STACK;    e.evType = EVC_TYPE_FAULT; e.precise = EVC_PREC_YES;  e.evClass = EVC_CLASS_CONTRIB; end
            SRC_PROTECT:  begin e.vector = VEC_PROTECT;  e.evType = EVC_TYPE_FAULT; e.precise = EVC_PREC_YES;  e.evClass = EVC_CLASS_CONTRIB; end
            SRC_PAGE:     begin e.vector = VEC_PAGE;     e.evType = EVC_TYPE_FAULT; e.precise = EVC_PREC_YES;
                                e.evClass = pgContrib ? EVC_CLASS_CONTRIB : EVC_CLASS_BENIGN; end
            SRC_ALIGN:    begin e.vector = VEC_ALIGN;    e.evType = EVC_TYPE_FAULT; e.precise = EVC_PREC_YES;  e.evClass = EVC_CLASS_BENIGN;  end
            SRC_DEVICE:   begin e.vector = VEC_DEVICE;   e.evType = EVC_TYPE_FAULT; e.precise = EVC_PREC_YES;  e.evClass = EVC_CLASS_BENIGN;  end
            SRC_HYPER:    begin e.vector = VEC_HYPER;    e.evType = EVC_TYPE_NONE;  e.precise = EVC_PREC_NONE; e.evClass = EVC_CLASS_BENIGN;  end
            SRC_VMMCOMM:  begin e.vector = VEC_VMMCOMM;  e.evType = EVC_TYPE_FAULT; e.precise = EVC_PREC_YES;  e.evClass = EVC_CLASS_CONTRIB; end
            SRC_SECURITY: begin e.vector = VEC_SECURITY; e.evType = EVC_TYPE_NONE;  e.precise = EVC_PREC_YES;  e.evClass = EVC_CLASS_CONTRIB; end
            default:      e = '0;
        endcase
        return e;
    endfunction

    // recognition after disables and breakpoint enables
    logic [SRC_COUNT-1:0] recognised;
    logic [SRC_COUNT-1:0] candidate;
    logic                 bkptFire;

    always_comb
    begin
        bkptFire = |(bkptHit & stateQ.bkptEn);
        recognised = srcEvent;
        recognised[SRC_DEBUG] = srcEvent[SRC_DEBUG] | bkptFire;
        recognised[SRC_DEVICE]  = srcEvent[SRC_DEVICE]  & stateQ.deviceEn;
        recognised[SRC_ALIGN]   = srcEvent[SRC_ALIGN]   & stateQ.alignEn;
        recognised[SRC_MACHINE] = srcEvent[SRC_MACHINE] & stateQ.machineEn;
        candidate = recognised | stateQ.heldMasked;
    end

    always_comb
    begin
        int         winner;
        logic       nmiTake;
        logic       extTake;
        evc_event_s ev;
        winner  = SRC_COUNT;
        nmiTake = 1'b0;
        extTake = 1'b0;
        ev      = '0;
        stateD  = stateQ;
        stateD.out = '0;

        if (cwWrite && current_privilege_level == PRIV_KERNEL)
        begin
            stateD.deviceEn  = control_word_zero[CW0_DEVICE_EN_BIT];
            stateD.alignEn   = control_word_four[CW4_ALIGN_EN_BIT];
            stateD.machineEn = control_word_four[CW4_MACHINE_EN_BIT];
        end
        if (bkptWrite && current_privilege_level == PRIV_KERNEL)
        begin
            stateD.bkptEn = bkptEnableIn;
        end

        // nmi latch; a request in the same cycle as the return still sees the block
        if (irqReturnDone)
        begin
            stateD.nmiBlocked = 1'b0;
        end
        if (nmiReq && !stateQ.nmiBlocked)
        begin
            stateD.nmiPending = 1'b1;
        end

        if (deliveryMask)
        begin
            stateD.heldMasked = candidate;
        end
        else
        begin
            for (int i = SRC_COUNT - 1; i >= 0; i--)
            begin
                if (candidate[i])
                begin
                    winner = i;
                end
            end
            stateD.heldMasked = '0;
            if (winner < SRC_COUNT)
            begin
                ev = classify(winner, debugIsTrap, pageContrib);
                // lower-priority sources stay held for the next slot
                stateD.heldMasked = candidate;
                stateD.heldMasked[winner] = 1'b0;
            end
            else if (stateQ.nmiPending && instrBoundary)
            begin
                nmiTake = 1'b1;
                ev = '0;
                ev.valid = 1'b1;
                ev.vector = VEC_NMI;
                ev.isNmi = 1'b1;
                stateD.nmiPending = 1'b0;
                stateD.nmiBlocked = 1'b1;
            end
            else if (swIntReq)
            begin
                ev = '0;
                ev.valid = 1'b1;
                ev.vector = swIntVector;
            end
            else if (external_maskable_irq && interrupt_enable_flag && instrBoundary)
            begin
                extTake = 1'b1;
                ev = '0;
                ev.valid = 1'b1;
                ev.vector = extVector;
                ev.evClass = EVC_CLASS_BENIGN;
                ev.isExt = 1'b1;
            end
        end
        if (nmiTake && nmiReq)
        begin
            stateD.nmiPending = 1'b0;
        end
        stateD.out = ev;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            stateQ            <= '0;
            stateQ.heldMasked <= RESET_MASKED;
        end
        else
        begin
            stateQ <= stateD;
        end
    end

    // ack pulses when the held request is taken
    assign extAck         = stateQ.out.valid & stateQ.out.isExt;
    assign accepted       = stateQ.out;
    assign deviceEnabled  = stateQ.deviceEn;
    assign alignEnabled   = stateQ.alignEn;
    assign machineEnabled = stateQ.machineEn;
    assign bkptEnabled    = stateQ.bkptEn;
    assign nmiBlocked     = stateQ.nmiBlocked;
    assign heldEvents     = stateQ.heldMasked;

endmodule
`default_nettype wire

// ### verif/evc_classifier_props.sv
`timescale 1ns/10ps
`default_nettype none
module evc_classifier_props
    import evc_pkg::*;
(
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 sys_rst,
    // inputs watched
    input  wire logic [SRC_COUNT-1:0] srcEvent,
    input  wire logic                 deliveryMask,
    input  wire logic                 swIntReq,
    input  wire logic [7:0]           extVector,
    input  wire logic                 irqReturnDone,
    input  wire logic                 interrupt_enable_flag,
    input  wire logic                 instrBoundary,
    input  wire logic [1:0]           current_privilege_level,
    input  wire logic                 cwWrite,
    input  wire logic [7:0]           control_word_four,
    // outputs watched
    input  wire logic                 extAck,
    input  wire logic                 alignEnabled,
    input  wire logic                 machineEnabled,
    input  wire logic                 nmiBlocked,
    input  wire logic [SRC_COUNT-1:0] heldEvents,
    input  wire evc_event_s           accepted
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    double_abort_a: assert property (
        srcEvent[SRC_DOUBLE] && !deliveryMask |=> accepted.valid && accepted.vector == VEC_DOUBLE
        && accepted.evType == EVC_TYPE_ABORT && accepted.precise == EVC_PREC_NO) else $error("double fault wrong");
    divide_vec_a: assert property (
        $onehot(srcEvent) && srcEvent[SRC_DIVIDE] && heldEvents == '0 && !deliveryMask |=> accepted.valid
        && accepted.vector == VEC_DIVIDE && accepted.evClass == EVC_CLASS_CONTRIB) else $error("divide error wrong");
    mask_hold_a: assert property (
        deliveryMask |=> !accepted.valid) else $error("delivery while masked");
    align_off_a: assert property (
        !alignEnabled && !cwWrite && srcEvent[SRC_ALIGN] && !heldEvents[SRC_ALIGN] && !swIntReq
        |=> !(accepted.valid && !accepted.isExt && accepted.vector == VEC_ALIGN)) else $error("disabled align seen");
    priv_guard_a: assert property (
        cwWrite && current_privilege_level != PRIV_KERNEL |=> $stable(alignEnabled) && $stable(machineEnabled))
        else $error("user level changed enables");
    kernel_write_a: assert property (
        cwWrite && current_privilege_level == PRIV_KERNEL
        |=> alignEnabled == $past(control_word_four[CW4_ALIGN_EN_BIT])
        && machineEnabled == $past(control_word_four[CW4_MACHINE_EN_BIT])) else $error("kernel write lost");
    ext_attr_a: assert property (
        extAck |-> accepted.valid && accepted.isExt && accepted.vector == $past(extVector)
        && accepted.evType == EVC_TYPE_NONE && accepted.precise == EVC_PREC_NONE && accepted.evClass == EVC_CLASS_BENIGN
        && $past(interrupt_enable_flag) && $past(instrBoundary)) else $error("external delivery wrong");
    nmi_block_a: assert property (
        accepted.valid && accepted.isNmi |-> accepted.vector == VEC_NMI ##1 (nmiBlocked || $past(irqReturnDone)))
        else $error("nmi vector or block wrong");
    nmi_silent_a: assert property (
        nmiBlocked && !irqReturnDone |=> !(accepted.valid && accepted.isNmi)) else $error("nmi while blocked");
endmodule
`default_nettype wire

// ### verif/evc_ext_source.sv
`timescale 1ns/10ps
`default_nettype none
module evc_ext_source
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    // bench request
    input  wire logic       reqGo,
    input  wire logic [7:0] reqVec,
    // interrupt lines
    input  wire logic       extAck,
    output logic            irqOut,
    output logic [7:0]      vecOut
);
    logic       pendQ;
    logic [7:0] vecQ;
    // held until taken
    // dropped on the ack itself, else the same request is seen twice
    assign irqOut = pendQ & ~extAck;
    assign vecOut = irqOut ? vecQ : ~vecQ;
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            pendQ <= 1'b0;
        else if (reqGo)
            pendQ <= 1'b1;
        else if (extAck)
            pendQ <= 1'b0;
        vecQ <= reqGo ? reqVec : vecQ ^ {8{sys_rst}};
    end
endmodule
`default_nettype wire

// ### verif/evc_classifier_tb.sv
`timescale 1ns/10ps
`default_nettype none
module evc_classifier_tb;
    import evc_pkg::*;
    logic                  mclk, sys_rst, debugIsTrap, pageContrib, deliveryMask, swIntReq, nmiReq, irqReturnDone;
    logic                  instrBoundary, interrupt_enable_flag, cwWrite, bkptWrite, extGo, external_maskable_irq;
    logic                  extAck, deviceEnabled, alignEnabled, machineEnabled, nmiBlocked;
    logic [SRC_COUNT-1:0]  srcEvent, heldEvents;
    logic [BKPT_COUNT-1:0] bkptHit, bkptEnableIn, bkptEnabled;
    logic [7:0]            swIntVector, extReqVec, extVector, control_word_zero, control_word_four;
    logic [1:0]            current_privilege_level;
    evc_event_s            accepted;
    logic [14:0]           expQ[$];
    logic [14:0]           e;
    logic [13:0]           got;
    int                    errorCnt, compares, seed;

    evc_classifier i_dut (.mclk, .sys_rst, .srcEvent, .debugIsTrap, .pageContrib, .bkptHit, .deliveryMask,
        .swIntReq, .swIntVector, .external_maskable_irq, .extVector, .extAck, .nmiReq, .irqReturnDone,
        .instrBoundary, .interrupt_enable_flag, .current_privilege_level, .cwWrite, .control_word_zero,
        .control_word_four, .bkptWrite, .bkptEnableIn, .deviceEnabled, .alignEnabled, .machineEnabled,
        .bkptEnabled, .nmiBlocked, .heldEvents, .accepted);
    evc_ext_source i_src (.mclk, .sys_rst, .reqGo(extGo), .reqVec(extReqVec), .extAck,
        .irqOut(external_maskable_irq), .vecOut(extVector));

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic fail(string m);
        errorCnt++;
        $display("ERROR at %0t: %s", $time, m);
    endtask
    task automatic chk(logic [15:0] g, logic [15:0] w, string m);
        compares++;
        if (g !== w) fail(m);
    endtask
    task automatic giveVerdict();
        $display("compares %0d, errors %0d", compares, errorCnt);
        if (errorCnt == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic tick(int n = 1);
        repeat (n) @(negedge mclk);
    endtask
    function automatic void want(logic [13:0] x, logic vOnly = 1'b0);
        expQ.push_back({vOnly, x});
    endfunction
    // expected vector and attributes of one exception source
    function automatic logic [13:0] attr(int s, logic trap, logic pc);
        logic [7:0] v [SRC_COUNT];
        evc_type_e  t;
        evc_prec_e  p;
        evc_class_e c;
        v = '{VEC_DOUBLE, VEC_MACHINE, VEC_DEBUG, VEC_DIVIDE, VEC_TASKSEG, VEC_STACK, VEC_PROTECT,
              VEC_PAGE, VEC_ALIGN, VEC_DEVICE, VEC_HYPER, VEC_VMMCOMM, VEC_SECURITY};
        t = (s == SRC_DOUBLE || s == SRC_MACHINE) ? EVC_TYPE_ABORT : (s == SRC_HYPER || s == SRC_SECURITY)
            ? EVC_TYPE_NONE : (s == SRC_DEBUG && trap) ? EVC_TYPE_TRAP : EVC_TYPE_FAULT;
        p = t == EVC_TYPE_ABORT ? EVC_PREC_NO : s == SRC_HYPER ? EVC_PREC_NONE : EVC_PREC_YES;
        c = s == SRC_DOUBLE ? EVC_CLASS_NONE : (s inside {SRC_MACHINE, SRC_DEBUG, SRC_ALIGN, SRC_DEVICE, SRC_HYPER}
            || (s == SRC_PAGE && !pc)) ? EVC_CLASS_BENIGN : EVC_CLASS_CONTRIB;
        return {v[s], t, p, c};
    endfunction
    // every delivered event must match the head of the model queue
    always @(negedge mclk)
    begin
        if (!sys_rst && accepted.valid !== 1'b0)
        begin
            compares++;
            got = {accepted.vector, accepted.evType, accepted.precise, accepted.evClass};
            e = expQ.size() ? expQ.pop_front() : 15'h7FFF;
            if (e[14]) got[5:0] = e[5:0];
            if (accepted.valid !== 1'b1 || got !== e[13:0]) fail("delivered event differs");
        end
    end
    task automatic drain();
        for (int n = 0; n < 40 && expQ.size() != 0; n++) tick();
        tick(4);
        chk(16'(expQ.size()), 16'h0000, "expected event missing");
        expQ.delete();
    endtask
    task automatic pulse(logic [SRC_COUNT-1:0] v);
        srcEvent = v;
        tick();
        srcEvent = '0;
    endtask
    task automatic ctl(logic [7:0] z, logic [7:0] f, logic [3:0] b);
        {control_word_zero, control_word_four, bkptEnableIn, cwWrite, bkptWrite} = {z, f, b, 2'b11};
        tick();
        {cwWrite, bkptWrite} = 2'b00;
        tick();
    endtask

    initial
    begin
        repeat (6000) @(posedge mclk);
        fail("watchdog expired");
        giveVerdict();
    end

    initial
    begin
        seed = 32'hB00400C1;
        {errorCnt, compares} = '0;
        {srcEvent, debugIsTrap, pageContrib, bkptHit, deliveryMask, swIntReq, swIntVector, extGo, extReqVec} = '0;
        {nmiReq, irqReturnDone, cwWrite, control_word_zero, control_word_four, bkptWrite, bkptEnableIn} = '0;
        {instrBoundary, interrupt_enable_flag, current_privilege_level, sys_rst} = 5'b10111;
        tick(9);
        sys_rst = 1'b0;
        chk({deviceEnabled, alignEnabled, machineEnabled, bkptEnabled}, 16'h0000, "enables after reset");
        ctl(8'hFF, 8'hFF, 4'hF);
        chk({deviceEnabled, alignEnabled, machineEnabled, bkptEnabled}, 16'h0000, "user write took");
        current_privilege_level = PRIV_KERNEL;
        ctl(8'hFF, 8'hFF, 4'b0101);
        chk({deviceEnabled, alignEnabled, machineEnabled, bkptEnabled}, 16'h0075, "kernel write lost");
        for (int s = 0; s < SRC_COUNT; s++)
        begin
            {debugIsTrap, pageContrib} = 2'($random(seed));
            want(attr(s, debugIsTrap, pageContrib));
            pulse(SRC_COUNT'(1) << s);
            drain();
        end
        for (int s = 0; s < SRC_COUNT; s++) want(attr(s, debugIsTrap, pageContrib));
        pulse('1);
        drain();
        deliveryMask = 1'b1;
        pulse(SRC_COUNT'(1) << SRC_DIVIDE | SRC_COUNT'(1) << SRC_PROTECT);
        tick(3);
        chk(16'(heldEvents), 16'(SRC_COUNT'(1) << SRC_DIVIDE | SRC_COUNT'(1) << SRC_PROTECT), "not held");
        want(attr(SRC_DIVIDE, 1'b0, 1'b0));
        want(attr(SRC_PROTECT, 1'b0, 1'b0));
        deliveryMask = 1'b0;
        drain();
        ctl(8'h00, 8'h00, 4'b0101);
        pulse(SRC_COUNT'(1) << SRC_ALIGN | SRC_COUNT'(1) << SRC_DEVICE | SRC_COUNT'(1) << SRC_MACHINE);
        drain();
        bkptHit = 4'b1010;
        tick();
        bkptHit = 4'b0000;
        drain();
        want(attr(SRC_DEBUG, debugIsTrap, 1'b0));
        bkptHit = 4'b0100;
        tick();
        bkptHit = 4'b0000;
        drain();
        for (int i = 0; i < 6; i++)
        begin
            swIntVector = i == 0 ? 8'h00 : i == 1 ? 8'h1F : i == 2 ? 8'hFF : 8'($random(seed));
            want({swIntVector, 6'h00}, 1'b1);
            swIntReq = 1'b1;
            tick();
            swIntReq = 1'b0;
            drain();
        end
        extReqVec = 8'($random(seed));
        extGo = 1'b1;
        tick();
        extGo = 1'b0;
        tick(5);
        {instrBoundary, interrupt_enable_flag} = 2'b01;
        tick(5);
        want({extReqVec, EVC_TYPE_NONE, EVC_PREC_NONE, EVC_CLASS_BENIGN});
        instrBoundary = 1'b1;
        drain();
        for (int i = 0; i < 3; i++)
        begin
            if (i != 1) want({VEC_NMI, 6'h00}, 1'b1);
            {nmiReq, irqReturnDone} = {1'b1, i == 2};
            tick();
            {nmiReq, irqReturnDone} = 2'b00;
            drain();
            chk(16'(nmiBlocked), 16'h0001, "nmi not blocked");
            // return pulse gets its own cycle so the next request sees the block cleared
            if (i == 1)
            begin
                irqReturnDone = 1'b1;
                tick();
                irqReturnDone = 1'b0;
                tick();
            end
        end
        giveVerdict();
    end
endmodule
bind evc_classifier evc_classifier_props i_props (.mclk, .sys_rst, .srcEvent, .deliveryMask, .swIntReq, .extVector,
    .irqReturnDone, .interrupt_enable_flag, .instrBoundary, .current_privilege_level, .cwWrite, .control_word_four,
    .extAck, .alignEnabled, .machineEnabled, .nmiBlocked, .heldEvents, .accepted);
`default_nettype wire
